// [include/cpc_params.svh]
// Constants of the cyclic parameter channel: layout, codes, offsets, reset values
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH

// ********************************************************
// Frame layout (byte 0 in the top bits of the 64-bit word)
// ********************************************************
`define CPC_FRAME_W        64
`define CPC_BYTE_MGMT      3'h0
`define CPC_BYTE_RSV       3'h1
`define CPC_BYTE_IDX_HI    3'h2
`define CPC_BYTE_IDX_LO    3'h3
`define CPC_BYTE_DATA_MSB  3'h4
`define CPC_BYTE_DATA_LSB  3'h7

// ********************************************************
// Management byte fields
// ********************************************************
`define CPC_SID_LSB        0
`define CPC_SID_MSB        3
`define CPC_LEN_LSB        4
`define CPC_LEN_MSB        5
`define CPC_HS_BIT         6
`define CPC_ERR_BIT        7
`define CPC_LEN_FOUR       2'h3
`define CPC_SID_READ       4'h1
`define CPC_SID_WRITE      4'h2
`define CPC_RSV_VALUE      8'h00

// ********************************************************
// Return codes: class, code, additional code
// ********************************************************
`define CPC_EC_SERVICE     8'h05
`define CPC_CODE_ILL_PAR   8'h05
`define CPC_EC_ACCESS      8'h06
`define CPC_CODE_TYPE      8'h08
`define CPC_EC_OTHER       8'h08
`define CPC_CODE_OTHER     8'h00
`define CPC_ADD_NONE       16'h0000
`define CPC_ADD_ILL_INDEX  16'h0010

// ********************************************************
// Register map and reset values
// ********************************************************
`define CPC_REG_CTRL       8'h00
`define CPC_REG_STATUS     8'h04
`define CPC_REG_MASK       8'h08
`define CPC_REG_COUNT      8'h0C
`define CPC_REG_LAST_IDX   8'h10
`define CPC_CTRL_EN_BIT    0
`define CPC_CTRL_RST       1'h1
`define CPC_MASK_RST       2'h0
`define CPC_ST_DONE_BIT    0
`define CPC_ST_ERR_BIT     1
`define CPC_ST_W           2

`endif

// [include/cpc_pkg.sv]
// Types shared by the parameter channel modules
package cpc_pkg;
  typedef enum logic [1:0] {
    CPC_IDLE,
    CPC_ACCESS,
    CPC_REPLY
  } cpc_state_t;
  typedef logic [63:0] cpc_frame_t;
  typedef logic [31:0] cpc_word_t;
  typedef logic [15:0] cpc_index_t;
endpackage

// [include/cpc_store_if.sv]
// Access path between the service interpreter and the parameter store
`timescale 1ns/1ps
`default_nettype none
interface cpc_store_if;
  logic                 rd;
  logic                 wr;
  cpc_pkg::cpc_index_t  addr;
  cpc_pkg::cpc_word_t   wdata;
  cpc_pkg::cpc_word_t   rdata;
  modport master (output rd, output wr, output addr, output wdata, input rdata);
  modport slave  (input rd, input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// [hw/cpc_store.sv]
// Parameter store: one 32-bit word per implemented index, registered read
`timescale 1ns/1ps
`default_nettype none
module cpc_store #(
  parameter int DEPTH = 32
) (
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  cpc_store_if.slave     bus
);
  import cpc_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  cpc_word_t       mem_ff [DEPTH];
  cpc_word_t       rdata_ff;
  wire [AW-1:0]    slot = bus.addr[AW-1:0];

  // Contents are not reset; only the read register has a defined start value
  always_ff @(posedge clk_in) begin
    if (bus.wr) begin
      mem_ff[slot] <= bus.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 32'h00000000;
    end else if (bus.rd) begin
      rdata_ff <= mem_ff[slot];
    end
  end

  assign bus.rdata = rdata_ff;
endmodule
`default_nettype wire

// [hw/cpc_top.sv]
// Cyclic parameter channel interpreter with register port and interrupt
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cpc_params.svh"
module cpc_top #(
  parameter int DEPTH = 32
) (
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  input  wire cpc_pkg::cpc_frame_t req_frame_in,
  input  wire logic            frame_valid_in,
  output logic                 rsp_frame_out_valid_out,
  output cpc_pkg::cpc_frame_t  rsp_frame_out,
  input  wire logic [7:0]      reg_addr_in,
  input  wire logic [31:0]     reg_wdata_in,
  input  wire logic            reg_wr_in,
  input  wire logic            reg_rd_in,
  output logic [31:0]          reg_rdata_out,
  output logic                 irq_out
);
  import cpc_pkg::*;

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic [7:0] frame_byte(input cpc_frame_t f, input logic [2:0] n);
    frame_byte = f[63 - 8*n -: 8];
  endfunction

  function automatic cpc_word_t err_word(input logic [7:0] cls, input logic [7:0] code,
                                         input logic [15:0] add);
    err_word = {cls, code, add};
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  cpc_state_t        state_ff;
  cpc_state_t        nxt_state;
  cpc_frame_t        req_ff;
  cpc_frame_t        rsp_ff;
  cpc_frame_t        nxt_rsp;
  logic              hs_ref_ff;
  logic              err_ff;
  cpc_word_t         errw_ff;
  logic              ctrl_en_ff;
  logic [1:0]        status_ff;
  logic [1:0]        nxt_status;
  logic [1:0]        mask_ff;
  logic [15:0]       count_ff;
  cpc_index_t        last_idx_ff;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic              rsp_upd_ff;

  cpc_store_if       st_if ();

  cpc_store #(
    .DEPTH (DEPTH)
  ) u_store (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .bus      (st_if)
  );

  // ********************************************************
  // Request decode
  // ********************************************************
  wire [7:0]  mgmt_in    = frame_byte(req_frame_in, `CPC_BYTE_MGMT);
  wire        hs_in      = mgmt_in[`CPC_HS_BIT];
  wire        hs_change  = frame_valid_in && (hs_in != hs_ref_ff);
  wire        start      = hs_change && ctrl_en_ff && (state_ff == CPC_IDLE);

  wire [7:0]  mgmt       = frame_byte(req_ff, `CPC_BYTE_MGMT);
  wire [3:0]  sid        = mgmt[`CPC_SID_MSB:`CPC_SID_LSB];
  wire [1:0]  len        = mgmt[`CPC_LEN_MSB:`CPC_LEN_LSB];
  wire [7:0]  rsv        = frame_byte(req_ff, `CPC_BYTE_RSV);
  wire cpc_index_t idx   = {frame_byte(req_ff, `CPC_BYTE_IDX_HI),
                            frame_byte(req_ff, `CPC_BYTE_IDX_LO)};
  wire cpc_word_t wdata  = req_ff[31:0];
  wire        is_read    = (sid == `CPC_SID_READ);
  wire        is_write   = (sid == `CPC_SID_WRITE);
  wire        bad_code   = (rsv != `CPC_RSV_VALUE) || !(is_read || is_write);
  wire        bad_len    = is_write && (len != `CPC_LEN_FOUR);
  wire        bad_idx    = (32'(idx) >= DEPTH);
  wire        any_err    = bad_code || bad_len || bad_idx;
  wire        in_access  = (state_ff == CPC_ACCESS);
  wire        in_reply   = (state_ff == CPC_REPLY);

  // Error priority: malformed service first, then length, then index
  wire cpc_word_t nxt_errw = bad_code ? err_word(`CPC_EC_SERVICE, `CPC_CODE_ILL_PAR,
                                                 `CPC_ADD_NONE) :
                             bad_len  ? err_word(`CPC_EC_ACCESS, `CPC_CODE_TYPE,
                                                 `CPC_ADD_NONE) :
                                        err_word(`CPC_EC_OTHER, `CPC_CODE_OTHER,
                                                 `CPC_ADD_ILL_INDEX);

  assign st_if.rd    = in_access && is_read && !any_err;
  assign st_if.wr    = in_access && is_write && !any_err;
  assign st_if.addr  = idx;
  assign st_if.wdata = wdata;

  // ********************************************************
  // Service sequencer
  // ********************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CPC_IDLE: begin
        if (start) begin
          nxt_state = CPC_ACCESS;
        end
      end
      CPC_ACCESS: begin
        nxt_state = CPC_REPLY;
      end
      CPC_REPLY: begin
        nxt_state = CPC_IDLE;
      end
      default: begin
        nxt_state = CPC_IDLE;
      end
    endcase
  end

  // Response: echo identifier/length, handshake copy, status bit, index, data
  wire cpc_word_t ok_data = is_read ? st_if.rdata : wdata;
  wire [7:0]  rsp_mgmt = {err_ff, hs_ref_ff, len, sid};
  always_comb begin
    nxt_rsp = rsp_ff;
    if (in_reply) begin
      nxt_rsp = {rsp_mgmt, `CPC_RSV_VALUE, idx,
                 err_ff ? errw_ff : ok_data};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= CPC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The whole frame is latched at the toggle, so later frames cannot tear it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_ff    <= 64'h0000000000000000;
      hs_ref_ff <= 1'h0;
    end else if (start) begin
      req_ff    <= req_frame_in;
      hs_ref_ff <= hs_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_ff  <= 1'h0;
      errw_ff <= 32'h00000000;
    end else if (in_access) begin
      err_ff  <= any_err;
      errw_ff <= nxt_errw;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_ff     <= 64'h0000000000000000;
      rsp_upd_ff <= 1'h0;
    end else begin
      rsp_ff     <= nxt_rsp;
      rsp_upd_ff <= in_reply;
    end
  end

  assign rsp_frame_out           = rsp_ff;
  assign rsp_frame_out_valid_out = rsp_upd_ff;

  // ********************************************************
  // Register port and interrupt
  // ********************************************************
  wire wr_ctrl   = reg_wr_in && (reg_addr_in == `CPC_REG_CTRL);
  wire wr_status = reg_wr_in && (reg_addr_in == `CPC_REG_STATUS);
  wire wr_mask   = reg_wr_in && (reg_addr_in == `CPC_REG_MASK);
  wire [1:0] ev  = {in_reply && err_ff, in_reply};

  // Hardware set wins over a write-one-to-clear in the same cycle
  always_comb begin
    nxt_status = status_ff;
    if (wr_status) begin
      nxt_status = status_ff & ~reg_wdata_in[`CPC_ST_W-1:0];
    end
    nxt_status = nxt_status | ev;
  end

  always_comb begin
    nxt_rdata = 32'h00000000;
    if (reg_addr_in == `CPC_REG_CTRL) begin
      nxt_rdata = {31'h00000000, ctrl_en_ff};
    end else if (reg_addr_in == `CPC_REG_STATUS) begin
      nxt_rdata = {30'h00000000, status_ff};
    end else if (reg_addr_in == `CPC_REG_MASK) begin
      nxt_rdata = {30'h00000000, mask_ff};
    end else if (reg_addr_in == `CPC_REG_COUNT) begin
      nxt_rdata = {16'h0000, count_ff};
    end else if (reg_addr_in == `CPC_REG_LAST_IDX) begin
      nxt_rdata = {16'h0000, last_idx_ff};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_en_ff <= `CPC_CTRL_RST;
      mask_ff    <= `CPC_MASK_RST;
      status_ff  <= 2'h0;
    end else begin
      status_ff <= nxt_status;
      if (wr_ctrl) begin
        ctrl_en_ff <= reg_wdata_in[`CPC_CTRL_EN_BIT];
      end
      if (wr_mask) begin
        mask_ff <= reg_wdata_in[`CPC_ST_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_ff    <= 16'h0000;
      last_idx_ff <= 16'h0000;
    end else if (in_reply) begin
      count_ff    <= count_ff + 16'h0001;
      last_idx_ff <= idx;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 32'h00000000;
    end else if (reg_rd_in) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign irq_out       = |(status_ff & mask_ff);

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_RSV_ZERO: assert property (
    frame_byte(rsp_frame_out, `CPC_BYTE_RSV) == `CPC_RSV_VALUE)
    else $error("response reserved byte not zero");

  AST_SID_ECHO: assert property (
    in_reply |=> rsp_frame_out[59:56] == $past(sid))
    else $error("service identifier not echoed");

  AST_NO_LEVEL_START: assert property (
    (state_ff == CPC_IDLE && !hs_change) |=> state_ff == CPC_IDLE)
    else $error("service started without handshake change");

  AST_START_SEQ: assert property (
    start |=> in_access ##1 in_reply ##1 state_ff == CPC_IDLE)
    else $error("service sequence broken");

  AST_HS_RETURN: assert property (
    start |-> ##3 rsp_frame_out[62] == $past(hs_in, 3))
    else $error("handshake not returned");

  AST_ERR_FLAG: assert property (
    in_access |-> ##2 rsp_frame_out[63] == $past(any_err, 2))
    else $error("status bit wrong");

  AST_IDX_ECHO: assert property (
    in_reply |=> rsp_frame_out[47:32] == $past(idx))
    else $error("index not echoed");

  AST_READ_DATA: assert property (
    (in_reply && !err_ff && is_read) |=> rsp_frame_out[31:0] == $past(st_if.rdata))
    else $error("read data misplaced");

  AST_LEN_ERR: assert property (
    (in_access && !bad_code && bad_len) |-> ##2 rsp_frame_out[31:0] == 32'h06080000)
    else $error("length error code wrong");

  AST_HOLD: assert property (
    (state_ff == CPC_IDLE && !start) |=> $stable(rsp_frame_out))
    else $error("response changed without new service");

  AST_VALID_PULSE: assert property (
    rsp_frame_out_valid_out |=> !rsp_frame_out_valid_out)
    else $error("response valid longer than one cycle");

  AST_VALID_AT_REPLY: assert property (
    in_reply |=> rsp_frame_out_valid_out)
    else $error("response valid missing after reply");

  // A refused toggle must leave the reference alone so it is taken later
  AST_REFUSED_HOLD: assert property (
    (hs_change && !start) |=> $stable(hs_ref_ff))
    else $error("handshake reference moved without a start");

  AST_CODE_ERR: assert property (
    (in_access && bad_code) |-> ##2
      rsp_frame_out[31:0] == {`CPC_EC_SERVICE, `CPC_CODE_ILL_PAR, `CPC_ADD_NONE})
    else $error("service error code wrong");

  AST_IDX_ERR: assert property (
    (in_access && !bad_code && !bad_len && bad_idx) |-> ##2
      rsp_frame_out[31:0] == {`CPC_EC_OTHER, `CPC_CODE_OTHER, `CPC_ADD_ILL_INDEX})
    else $error("index error code wrong");

  AST_WRITE_ECHO: assert property (
    (in_reply && !err_ff && is_write) |=> rsp_frame_out[31:0] == $past(wdata))
    else $error("write data not echoed");

  AST_DONE_SET: assert property (
    in_reply |=> status_ff[`CPC_ST_DONE_BIT])
    else $error("done status not set");

  CV_READ_OK: cover property (in_reply && is_read && !err_ff);
  CV_WRITE_OK: cover property (in_reply && is_write && !err_ff);
  CV_BAD_LEN: cover property (in_access && bad_len);
  CV_BAD_IDX: cover property (in_access && bad_idx && !bad_code);
  CV_REFUSED: cover property (hs_change && !start);
endmodule
`default_nettype wire

// [sim/cpc_master_model.sv]
// Behavioural fieldbus master that builds parameter channel frames
`timescale 1ns/1ps
`default_nettype none
module cpc_master_model
  import cpc_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  output cpc_frame_t  req_frame_out,
  output logic        frame_valid_out
);
  logic hs_ff;

  initial begin
    req_frame_out = '0;
    frame_valid_out = 1'b0;
    hs_ff = 1'b0;
  end

  // ****************************************
  // Cyclic exchange
  // ****************************************
  // The frame is offered every bus cycle as one whole 64-bit block
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_valid_out <= 1'b0;
    end else begin
      frame_valid_out <= 1'b1;
    end
  end

  // Contents change while the handshake stays put, so nothing runs
  task automatic stage(input logic [3:0] sid, input logic [1:0] len, input cpc_index_t idx,
                       input cpc_word_t data, input logic [7:0] rsv);
    @(posedge clk_in);
    req_frame_out <= {1'b0, hs_ff, len, sid, rsv, idx, data};
  endtask

  // A full bus cycle of settled contents precedes the toggle
  task automatic issue(input logic [3:0] sid, input logic [1:0] len, input cpc_index_t idx,
                       input cpc_word_t data, input logic [7:0] rsv);
    stage(sid, len, idx, data, rsv);
    @(posedge clk_in);
    hs_ff = ~hs_ff;
    req_frame_out[62] <= hs_ff;
  endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
// Self-checking testbench of the parameter channel interpreter
`timescale 1ns/1ps
`default_nettype none
`include "cpc_params.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); num_errors++; end end
module tb;
  import cpc_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  cpc_frame_t  req_frame;
  logic        frame_valid;
  logic        rsp_valid;
  cpc_frame_t  rsp_frame;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        irq;
  int          num_errors = 0;
  int          check_count = 0;

  always #12.5 clk_in = ~clk_in;

  cpc_master_model m (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_frame_out(req_frame),
                      .frame_valid_out(frame_valid));
  cpc_top #(.DEPTH(32)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_frame_in(req_frame),
    .frame_valid_in(frame_valid), .rsp_frame_out_valid_out(rsp_valid), .rsp_frame_out(rsp_frame),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .irq_out(irq));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    @(negedge clk_in);
    d = reg_rdata;
  endtask

  // Bounded wait for the response pulse; returns the negedges counted
  task automatic wait_rsp(output int n);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (rsp_valid !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic svc(input logic [3:0] sid, input logic [1:0] len, input cpc_index_t idx,
                     input cpc_word_t data, input logic [7:0] rsv, output cpc_frame_t r);
    int n;
    m.issue(sid, len, idx, data, rsv);
    wait_rsp(n);
    r = rsp_frame;
    `CHK("latency", 4, n)
    `CHK("handshake", m.hs_ff, r[62])
    `CHK("service id", sid, r[59:56])
    `CHK("reserved", 8'h00, r[55:48])
    `CHK("index", idx, r[47:32])
    @(negedge clk_in);
    `CHK("valid pulse", 1'b0, rsp_valid)
    `CHK("response held", r, rsp_frame)
  endtask

  task automatic err_case(input logic [3:0] sid, input logic [1:0] len, input cpc_index_t idx,
                          input logic [7:0] rsv, input cpc_word_t ex);
    cpc_frame_t r;
    svc(sid, len, idx, 32'h0, rsv, r);
    `CHK("error flag", 1'b1, r[63])
    `CHK("return code", ex, r[31:0])
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_regs();
    logic [31:0] d;
    reg_read(`CPC_REG_CTRL, d);
    `CHK("ctrl reset", 32'h1, d)
    @(negedge clk_in);
    `CHK("rdata one cycle", 32'h0, reg_rdata)
    reg_read(`CPC_REG_MASK, d);
    `CHK("mask reset", 32'h0, d)
    reg_write(8'h20, 32'hFFFFFFFF);
    reg_read(8'h20, d);
    `CHK("unmapped", 32'h0, d)
    $display("test reset_regs done");
  endtask

  task automatic t_write_read();
    cpc_frame_t r;
    svc(`CPC_SID_WRITE, `CPC_LEN_FOUR, 16'h0005, 32'hA1B2C3D4, `CPC_RSV_VALUE, r);
    `CHK("write ok", 1'b0, r[63])
    `CHK("write echo", 32'hA1B2C3D4, r[31:0])
    svc(`CPC_SID_WRITE, `CPC_LEN_FOUR, 16'h001F, 32'h00000077, `CPC_RSV_VALUE, r);
    `CHK("top index ok", 1'b0, r[63])
    svc(`CPC_SID_READ, 2'h0, 16'h0005, 32'h5A5A5A5A, `CPC_RSV_VALUE, r);
    `CHK("read ok", 1'b0, r[63])
    `CHK("data msb", 8'hA1, r[31:24])
    `CHK("low word", 16'hC3D4, r[15:0])
    $display("test write_read done");
  endtask

  task automatic t_hold();
    cpc_frame_t snap;
    cpc_frame_t r;
    int pulses;
    snap = rsp_frame;
    pulses = 0;
    m.stage(`CPC_SID_WRITE, `CPC_LEN_FOUR, 16'h0005, 32'h11111111, `CPC_RSV_VALUE);
    repeat (12) begin
      @(negedge clk_in);
      if (rsp_valid === 1'b1) begin
        pulses++;
      end
    end
    `CHK("repeat pulses", 0, pulses)
    `CHK("held response", snap, rsp_frame)
    svc(`CPC_SID_READ, `CPC_LEN_FOUR, 16'h0005, 32'h0, `CPC_RSV_VALUE, r);
    `CHK("no stray write", 32'hA1B2C3D4, r[31:0])
    $display("test hold done");
  endtask

  task automatic t_errors();
    err_case(4'h7, `CPC_LEN_FOUR, 16'h0003, 8'h00,
             {`CPC_EC_SERVICE, `CPC_CODE_ILL_PAR, `CPC_ADD_NONE});
    err_case(`CPC_SID_READ, `CPC_LEN_FOUR, 16'h0003, 8'h5A,
             {`CPC_EC_SERVICE, `CPC_CODE_ILL_PAR, `CPC_ADD_NONE});
    err_case(`CPC_SID_WRITE, 2'h1, 16'h0003, 8'h00,
             {`CPC_EC_ACCESS, `CPC_CODE_TYPE, `CPC_ADD_NONE});
    err_case(`CPC_SID_WRITE, 2'h0, 16'h0003, 8'h00,
             {`CPC_EC_ACCESS, `CPC_CODE_TYPE, `CPC_ADD_NONE});
    err_case(`CPC_SID_READ, `CPC_LEN_FOUR, 16'h0020, 8'h00,
             {`CPC_EC_OTHER, `CPC_CODE_OTHER, `CPC_ADD_ILL_INDEX});
    $display("test errors done");
  endtask

  task automatic t_irq();
    logic [31:0] d;
    reg_read(`CPC_REG_STATUS, d);
    `CHK("status events", 32'h3, d)
    `CHK("irq masked", 1'b0, irq)
    reg_write(`CPC_REG_MASK, 32'h2);
    @(negedge clk_in);
    `CHK("irq raised", 1'b1, irq)
    reg_write(`CPC_REG_STATUS, 32'h2);
    @(negedge clk_in);
    `CHK("irq cleared", 1'b0, irq)
    reg_read(`CPC_REG_STATUS, d);
    `CHK("status after clear", 32'h1, d)
    reg_read(`CPC_REG_COUNT, d);
    `CHK("service count", 32'h9, d)
    reg_read(`CPC_REG_LAST_IDX, d);
    `CHK("last index", 32'h20, d)
    $display("test irq done");
  endtask

  // A toggle refused while disabled is taken once enabled again
  task automatic t_disable();
    int n;
    int pulses;
    pulses = 0;
    reg_write(`CPC_REG_CTRL, 32'h0);
    m.issue(`CPC_SID_READ, `CPC_LEN_FOUR, 16'h001F, 32'h0, `CPC_RSV_VALUE);
    repeat (10) begin
      @(negedge clk_in);
      if (rsp_valid === 1'b1) begin
        pulses++;
      end
    end
    `CHK("disabled pulses", 0, pulses)
    reg_write(`CPC_REG_CTRL, 32'h1);
    wait_rsp(n);
    `CHK("late handshake", m.hs_ff, rsp_frame[62])
    `CHK("late data", 32'h00000077, rsp_frame[31:0])
    $display("test disable done");
  endtask

  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset_regs();
    t_write_read();
    t_hold();
    t_errors();
    t_irq();
    t_disable();
    conclude();
  end
endmodule
`default_nettype wire
